/* inc/pla_params.svh */
`ifndef PLA_PARAMS_SVH
`define PLA_PARAMS_SVH
// register indices; byte address is four times the index
`define PLA_IDX_LEN 8'h38
`define PLA_IDX_STA 8'h39
`define PLA_IDX_ALL 8'h3A
`define PLA_IDX_AUTO 8'h3B
`define PLA_IDX_CTRL 8'h3C
`define PLA_IDX_STAT 8'h3D
`define PLA_ADDR_W 8
// reset values
`define PLA_RST_LEN 8'h40
`define PLA_RST_STA 8'h00
`define PLA_RST_ALL 8'h00
`define PLA_RST_AUTO 8'h00
`define PLA_RST_CTRL 8'h08
// automatic_state_switch fields
`define PLA_ENTRY_HI 7
`define PLA_ENTRY_LO 5
`define PLA_EXIT_HI 4
`define PLA_EXIT_LO 2
`define PLA_INTERIM_HI 1
`define PLA_INTERIM_LO 0
// control fields
`define PLA_CTRL_KIND 0
`define PLA_CTRL_FILT_HI 2
`define PLA_CTRL_FILT_LO 1
`define PLA_CTRL_MODE_HI 5
`define PLA_CTRL_MODE_LO 3
// trigger codes
`define PLA_TRIG_OFF 3'h0
`define PLA_TRIG_QUEUE 3'h1
`define PLA_TRIG_SYNC 3'h6
// filter codes
`define PLA_FILT_OFF 2'h0
`define PLA_FILT_STA 2'h1
`define PLA_FILT_ALL 2'h2
// axi responses
`define PLA_RESP_OK 2'h0
`define PLA_RESP_ERR 2'h2
`endif

/* inc/pla_pkg.sv */
package pla_pkg;
  // automatic switching states, gray along prog -> interim
  typedef enum logic [1:0] {
    PLA_ST_PROG = 2'h0,
    PLA_ST_INTERIM = 2'h1
  } pla_auto_st_t;
  // radio operating modes
  typedef enum logic [2:0] {
    PLA_MODE_DOZE = 3'h0,
    PLA_MODE_IDLE = 3'h1,
    PLA_MODE_SYNTH = 3'h2,
    PLA_MODE_TX = 3'h3,
    PLA_MODE_RX = 3'h4
  } pla_mode_t;
endpackage

/* rtl/pla_top.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - fixed frames use length register exactly
// - variable frames: receive maximum, transmit ignores
// - station identifier register compared in filtering
// - all-stations identifier is second accepted address
// - entry trigger field bits 7-5, 000 off
// - exit trigger field bits 4-2, 000 none
// - entry code 001: queue-nonempty rising edge
// - entry code 110: sync-match rising edge
// - filter 01 station, 10 also all-stations
// - interim select 00 doze, 01 idle, 10 receive
`include "pla_params.svh"
module pla_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [`PLA_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`PLA_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // packet engine events
  input wire logic queue_nonempty_flag,
  input wire logic queue_level_flag,
  input wire logic crc_ok_flag,
  input wire logic payload_ready_flag,
  input wire logic frame_sent_flag,
  input wire logic sync_match_flag,
  input wire logic timeout_flag,
  // receive frame stream
  input wire logic rx_frame_start,
  input wire logic rx_len_valid,
  input wire logic [7:0] rx_len_byte,
  input wire logic rx_addr_valid,
  input wire logic [7:0] rx_addr_byte,
  input wire logic rx_frame_end,
  // length and frame outputs
  output logic [7:0] tx_length,
  output logic tx_length_used,
  output logic [7:0] rx_length_limit,
  output logic rx_length_exact,
  output logic payload_discard,
  output logic frame_received,
  // radio mode
  output logic [2:0] radio_mode
);

  // register file and local state
  logic [7:0] len_q, len_d, sta_q, sta_d, all_q, all_d;
  logic [7:0] auto_q, auto_d, ctrl_q, ctrl_d;
  logic [6:0] ev_q;
  logic disc_q, disc_d, frx_q, frx_d;
  logic [7:0] txl_q, txl_d, rxl_q, rxl_d;
  logic txu_q, txu_d, rxe_q, rxe_d;
  logic [2:0] mode_q, mode_d;
  pla_pkg::pla_auto_st_t st_q, st_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [`PLA_ADDR_W-1:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic wse_q, wse_d, bv_q, bv_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic rv_q, rv_d;
  logic [31:0] rd_q, rd_d;
  logic do_wr, wr_hit;
  logic [8:0] wr_idx;
  logic [6:0] ev_now, ev_rise;
  logic q_fall;
  logic [7:0] ent_vec, ext_vec;
  logic [2:0] ent_code, ext_code;
  logic [1:0] filt;
  logic var_kind, ent_hit, ext_hit;

  // register index from a byte address, flags mapped ones in bit 8
  function automatic logic [8:0] reg_idx(input logic [`PLA_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = {2'h0, a[`PLA_ADDR_W-1:2]};
    if (a[1:0] != 2'h0 || idx < `PLA_IDX_LEN || idx > `PLA_IDX_STAT) begin
      reg_idx = {1'b0, idx};
    end else begin
      reg_idx = {1'b1, idx};
    end
  endfunction

  // selected trigger from an event vector
  function automatic logic trig_hit(input logic [2:0] code, input logic [7:0] vec);
    trig_hit = vec[code];
  endfunction

  // fields
  assign ent_code = auto_q[`PLA_ENTRY_HI:`PLA_ENTRY_LO];
  assign ext_code = auto_q[`PLA_EXIT_HI:`PLA_EXIT_LO];
  assign filt = ctrl_q[`PLA_CTRL_FILT_HI:`PLA_CTRL_FILT_LO];
  assign var_kind = ctrl_q[`PLA_CTRL_KIND];

  // event edges
  assign ev_now = {timeout_flag, sync_match_flag, frame_sent_flag, payload_ready_flag,
                   crc_ok_flag, queue_level_flag, queue_nonempty_flag};
  assign ev_rise = ev_now & ~ev_q;
  assign q_fall = ev_q[0] & ~queue_nonempty_flag;
  // entry: 001 queue, 110 sync, 111 queue fall, others in between
  assign ent_vec = {q_fall, ev_rise[5], ev_rise[4], ev_rise[3],
                    ev_rise[2], ev_rise[1], ev_rise[0], 1'b0};
  assign ext_vec = {1'b0, ev_rise[6], ev_rise[4], ev_rise[3] | ev_rise[6],
                    ev_rise[2] | ev_rise[6], ev_rise[1] | ev_rise[6], q_fall, 1'b0};
  assign ent_hit = trig_hit(ent_code, ent_vec);
  assign ext_hit = trig_hit(ext_code, ext_vec);

  // axi write path
  assign awready = !aw_hold_q && !bv_q;
  assign wready = !w_hold_q && !bv_q;
  assign do_wr = (aw_hold_q || (awvalid && awready)) && (w_hold_q || (wvalid && wready));
  assign wr_idx = reg_idx(aw_hold_q ? wa_q : awaddr);
  assign wr_hit = wr_idx[8];
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    wa_d = wa_q;
    wd_d = wd_q;
    wse_d = wse_q;
    bv_d = bv_q;
    br_d = br_q;
    if (awvalid && awready) begin
      aw_hold_d = 1'b1;
      wa_d = awaddr;
    end
    if (wvalid && wready) begin
      w_hold_d = 1'b1;
      wd_d = wdata[7:0];
      wse_d = wstrb[0];
    end
    if (do_wr) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bv_d = 1'b1;
      br_d = wr_hit ? `PLA_RESP_OK : `PLA_RESP_ERR;
    end
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
  end

  // register writes
  always_comb begin
    logic [8:0] wi;
    logic [7:0] wv;
    logic ws;
    wi = reg_idx(aw_hold_q ? wa_q : awaddr);
    wv = w_hold_q ? wd_q : wdata[7:0];
    ws = w_hold_q ? wse_q : wstrb[0];
    len_d = len_q;
    sta_d = sta_q;
    all_d = all_q;
    auto_d = auto_q;
    ctrl_d = ctrl_q;
    if (do_wr && ws && wi[8]) begin
      case (wi[7:0])
        `PLA_IDX_LEN: len_d = wv;
        `PLA_IDX_STA: sta_d = wv;
        `PLA_IDX_ALL: all_d = wv;
        `PLA_IDX_AUTO: auto_d = wv;
        `PLA_IDX_CTRL: ctrl_d = {2'h0, wv[5:0]};
        default: ;
      endcase
    end
  end

  // axi read path
  assign arready = !rv_q;
  always_comb begin
    logic [8:0] ri;
    ri = reg_idx(araddr);
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (rv_q && rready) begin
      rv_d = 1'b0;
    end
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rr_d = ri[8] ? `PLA_RESP_OK : `PLA_RESP_ERR;
      case (ri[7:0])
        `PLA_IDX_LEN: rd_d = {24'h0, len_q};
        `PLA_IDX_STA: rd_d = {24'h0, sta_q};
        `PLA_IDX_ALL: rd_d = {24'h0, all_q};
        `PLA_IDX_AUTO: rd_d = {24'h0, auto_q};
        `PLA_IDX_CTRL: rd_d = {24'h0, ctrl_q};
        `PLA_IDX_STAT: rd_d = {27'h0, disc_q, mode_q, st_q == pla_pkg::PLA_ST_INTERIM};
        default: rd_d = 32'h0;
      endcase
      if (!ri[8]) begin
        rd_d = 32'h0;
      end
    end
  end

  // automatic switching and radio mode
  always_comb begin
    st_d = st_q;
    case (st_q)
      pla_pkg::PLA_ST_PROG: begin
        if (ent_code != `PLA_TRIG_OFF && ent_hit) begin
          st_d = pla_pkg::PLA_ST_INTERIM;
        end
      end
      pla_pkg::PLA_ST_INTERIM: begin
        if (ent_code == `PLA_TRIG_OFF || (ext_code != `PLA_TRIG_OFF && ext_hit)) begin
          st_d = pla_pkg::PLA_ST_PROG;
        end
      end
      default: st_d = pla_pkg::PLA_ST_PROG;
    endcase
    mode_d = ctrl_q[`PLA_CTRL_MODE_HI:`PLA_CTRL_MODE_LO];
    if (st_d == pla_pkg::PLA_ST_INTERIM) begin
      // next register value, so a rewrite while in interim takes effect with it
      case (auto_d[`PLA_INTERIM_HI:`PLA_INTERIM_LO])
        2'h0: mode_d = pla_pkg::PLA_MODE_DOZE;
        2'h2: mode_d = pla_pkg::PLA_MODE_RX;
        default: mode_d = pla_pkg::PLA_MODE_IDLE;
      endcase
    end
  end

  // length outputs and receive filtering
  always_comb begin
    txl_d = var_kind ? 8'h00 : len_q;
    txu_d = !var_kind;
    rxl_d = len_q;
    rxe_d = !var_kind;
    disc_d = rx_frame_start ? 1'b0 : disc_q;
    if (rx_len_valid && var_kind && rx_len_byte > len_q) begin
      disc_d = 1'b1;
    end
    if (rx_addr_valid) begin
      case (filt)
        `PLA_FILT_STA: if (rx_addr_byte != sta_q) disc_d = 1'b1;
        `PLA_FILT_ALL: if (rx_addr_byte != sta_q && rx_addr_byte != all_q) disc_d = 1'b1;
        default: ;
      endcase
    end
    frx_d = rx_frame_end && !disc_d;
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_q <= `PLA_RST_LEN;
      sta_q <= `PLA_RST_STA;
      all_q <= `PLA_RST_ALL;
      auto_q <= `PLA_RST_AUTO;
      ctrl_q <= `PLA_RST_CTRL;
      ev_q <= 7'h00;
      st_q <= pla_pkg::PLA_ST_PROG;
      mode_q <= pla_pkg::PLA_MODE_IDLE;
      disc_q <= 1'b0;
      frx_q <= 1'b0;
      txl_q <= 8'h00;
      txu_q <= 1'b0;
      rxl_q <= 8'h00;
      rxe_q <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      wa_q <= '0;
      wd_q <= 8'h00;
      wse_q <= 1'b0;
      bv_q <= 1'b0;
      br_q <= 2'h0;
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= 2'h0;
    end else begin
      len_q <= len_d;
      sta_q <= sta_d;
      all_q <= all_d;
      auto_q <= auto_d;
      ctrl_q <= ctrl_d;
      ev_q <= ev_now;
      st_q <= st_d;
      mode_q <= mode_d;
      disc_q <= disc_d;
      frx_q <= frx_d;
      txl_q <= txl_d;
      txu_q <= txu_d;
      rxl_q <= rxl_d;
      rxe_q <= rxe_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      wse_q <= wse_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  // outputs
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign tx_length = txl_q;
  assign tx_length_used = txu_q;
  assign rx_length_limit = rxl_q;
  assign rx_length_exact = rxe_q;
  assign payload_discard = disc_q;
  assign frame_received = frx_q;
  assign radio_mode = mode_q;

  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_fixed_length: assert property (
    aresetn && !var_kind ##1 !var_kind |-> tx_length == $past(len_q) && rx_length_exact)
    else $error("fixed length not applied");
  chk_var_tx_ignore: assert property (var_kind ##1 var_kind |-> !tx_length_used && !rx_length_exact)
    else $error("variable length used in transmit");
  chk_var_overlen: assert property (rx_len_valid && var_kind && rx_len_byte > len_q |=> payload_discard)
    else $error("overlong frame kept");
  chk_station_miss: assert property (
    rx_addr_valid && filt == `PLA_FILT_STA && rx_addr_byte != sta_q |=> payload_discard)
    else $error("station mismatch kept");
  chk_all_accept: assert property (
    rx_addr_valid && filt == `PLA_FILT_ALL && rx_addr_byte == all_q && (rx_frame_start || !payload_discard)
    && !(rx_len_valid && var_kind && rx_len_byte > len_q) |=> !payload_discard)
    else $error("all-stations frame dropped");
  chk_entry_off: assert property (ent_code == `PLA_TRIG_OFF |=> st_q == pla_pkg::PLA_ST_PROG)
    else $error("switching active while off");
  chk_exit_none: assert property (
    st_q == pla_pkg::PLA_ST_INTERIM && ext_code == `PLA_TRIG_OFF
    && ent_code != `PLA_TRIG_OFF |=> st_q == pla_pkg::PLA_ST_INTERIM)
    else $error("left interim with no exit");
  chk_entry_queue: assert property (
    st_q == pla_pkg::PLA_ST_PROG && ent_code == `PLA_TRIG_QUEUE
    && $rose(queue_nonempty_flag) |=> st_q == pla_pkg::PLA_ST_INTERIM)
    else $error("queue entry missed");
  chk_entry_sync: assert property (
    st_q == pla_pkg::PLA_ST_PROG && ent_code == `PLA_TRIG_SYNC
    && $rose(sync_match_flag) |=> st_q == pla_pkg::PLA_ST_INTERIM)
    else $error("sync entry missed");
  chk_interim_mode: assert property (
    st_q == pla_pkg::PLA_ST_INTERIM && auto_q[1:0] == 2'h2 |-> radio_mode == pla_pkg::PLA_MODE_RX)
    else $error("interim mode wrong");
  chk_exit_return: assert property (
    st_q == pla_pkg::PLA_ST_INTERIM && ext_code != `PLA_TRIG_OFF && ext_hit
    |=> radio_mode == $past(ctrl_q[5:3]))
    else $error("no return to programmed mode");
  chk_reject_quiet: assert property (rx_frame_end && disc_d |=> !frame_received)
    else $error("rejected frame indicated");
  cov_enter: cover property (st_q == pla_pkg::PLA_ST_PROG ##1 st_q == pla_pkg::PLA_ST_INTERIM);
  cov_exit: cover property (st_q == pla_pkg::PLA_ST_INTERIM ##1 st_q == pla_pkg::PLA_ST_PROG);
  cov_reject: cover property (rx_frame_end && disc_d);
  cov_accept: cover property (frame_received && filt != `PLA_FILT_OFF);

endmodule // pla_top

/* tb/packet_length_address_automode_tb_top.sv */
`timescale 1ns/1ps
`include "pla_params.svh"
module packet_length_address_automode_tb_top;
  // design ports
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, rx_len_byte, rx_addr_byte, tx_length, rx_length_limit;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic queue_nonempty_flag, queue_level_flag, crc_ok_flag, payload_ready_flag, frame_sent_flag;
  logic sync_match_flag, timeout_flag, rx_frame_start, rx_len_valid, rx_addr_valid, rx_frame_end;
  logic tx_length_used, rx_length_exact, payload_discard, frame_received;
  logic [2:0] radio_mode;
  // bench state
  int fails, checks, cycles;
  logic [33:0] exp_q[$];
  logic [7:0] sa, ba, oa, len;
  logic [2:0] mode_tab [3];

  pla_top i_pla_top (.*);

  // clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // compare and count
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict
  task automatic end_of_test();
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one axi transfer; the response is judged by the watcher
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    bit pa, pw;
    logic ra, rw;
    exp_q.push_back(e);
    pa = 1'b1;
    pw = wr;
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
    end
    while (pa || pw || exp_q.size() != 0) begin
      #1;
      ra = wr ? awready : arready;
      rw = wready;
      @(posedge aclk);
      if (pa && ra) begin
        pa = 1'b0;
        if (wr) awvalid <= 1'b0;
        else arvalid <= 1'b0;
      end
      if (pw && rw) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    axi(1'b1, idx << 2, {24'h0, v}, {`PLA_RESP_OK, 32'h0});
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] v);
    axi(1'b0, idx << 2, 32'h0, {`PLA_RESP_OK, 24'h0, v});
  endtask

  // one received frame with address and length bytes
  task automatic frame(input logic [7:0] a, input logic [7:0] l, input logic ok);
    rx_frame_start <= 1'b1;
    @(posedge aclk);
    rx_frame_start <= 1'b0;
    rx_addr_valid <= 1'b1;
    rx_addr_byte <= a;
    rx_len_valid <= 1'b1;
    rx_len_byte <= l;
    @(posedge aclk);
    rx_addr_valid <= 1'b0;
    rx_len_valid <= 1'b0;
    rx_addr_byte <= ~a;
    rx_len_byte <= ~l;
    rx_frame_end <= 1'b1;
    @(posedge aclk);
    rx_frame_end <= 1'b0;
    @(negedge aclk);
    chk(34'(frame_received), 34'(ok));
    chk(34'(payload_discard), 34'(!ok));
    @(posedge aclk);
  endtask

  // watcher: oldest note against each response
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rvalid === 1'b1 && rready) chk({rresp, rdata}, exp_q.pop_front());
  end

  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {queue_nonempty_flag, queue_level_flag, crc_ok_flag, payload_ready_flag, frame_sent_flag} = '0;
    {sync_match_flag, timeout_flag, rx_frame_start, rx_len_valid, rx_addr_valid, rx_frame_end} = '0;
    {rx_len_byte, rx_addr_byte} = '0;
    {bready, rready, wstrb} = 6'h3F;
    mode_tab = '{pla_pkg::PLA_MODE_DOZE, pla_pkg::PLA_MODE_IDLE, pla_pkg::PLA_MODE_RX};
    void'($urandom(93255));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk(34'(tx_length), 34'h40);
    chk(34'({tx_length_used, rx_length_exact}), 34'h3);
    @(posedge aclk);
    rd(`PLA_IDX_LEN, `PLA_RST_LEN);
    rd(`PLA_IDX_STA, `PLA_RST_STA);
    rd(`PLA_IDX_ALL, `PLA_RST_ALL);
    rd(`PLA_IDX_AUTO, `PLA_RST_AUTO);
    axi(1'b0, 8'h00, 32'h0, {`PLA_RESP_ERR, 32'h0});
    axi(1'b1, 8'h04, 32'hFF, {`PLA_RESP_ERR, 32'h0});
    // random identifiers and length
    sa = 8'($urandom);
    ba = sa ^ 8'h0F;
    oa = sa ^ 8'hF0;
    len = 8'($urandom % 255);
    wr(`PLA_IDX_STA, sa);
    wr(`PLA_IDX_ALL, ba);
    wr(`PLA_IDX_LEN, len);
    rd(`PLA_IDX_STA, sa);
    rd(`PLA_IDX_ALL, ba);
    rd(`PLA_IDX_LEN, len);
    chk(34'(tx_length), 34'(len));
    // variable frames, station filter only
    wr(`PLA_IDX_CTRL, 8'h0B);
    @(negedge aclk);
    chk(34'({tx_length, tx_length_used}), 34'h0);
    chk(34'({rx_length_limit, rx_length_exact}), {25'h0, len, 1'b0});
    @(posedge aclk);
    frame(sa, len, 1'b1);
    frame(ba, len, 1'b0);
    frame(sa, len + 8'h01, 1'b0);
    // all-stations also accepted
    wr(`PLA_IDX_CTRL, 8'h0D);
    frame(ba, len, 1'b1);
    frame(oa, len, 1'b0);
    wr(`PLA_IDX_CTRL, 8'h09);
    frame(oa, len, 1'b1);
    // automatic switching, programmed mode transmit
    wr(`PLA_IDX_CTRL, 8'h18);
    rd(`PLA_IDX_CTRL, 8'h18);
    for (int i = 0; i < 3; i++) begin
      wr(`PLA_IDX_AUTO, 8'hD8 | 8'(i));
      sync_match_flag <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(34'(radio_mode), 34'(mode_tab[i]));
      @(posedge aclk);
      sync_match_flag <= 1'b0;
      timeout_flag <= 1'b1;
      @(posedge aclk);
      timeout_flag <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk(34'(radio_mode), 34'(pla_pkg::PLA_MODE_TX));
      @(posedge aclk);
    end
    // queue entry and exit, doze interim
    wr(`PLA_IDX_AUTO, 8'h24);
    queue_nonempty_flag <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(34'(radio_mode), 34'(pla_pkg::PLA_MODE_DOZE));
    @(posedge aclk);
    rd(`PLA_IDX_STAT, 8'h01);
    queue_nonempty_flag <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(34'(radio_mode), 34'(pla_pkg::PLA_MODE_TX));
    @(posedge aclk);
    // no exit code: interim holds through a timeout
    wr(`PLA_IDX_AUTO, 8'hC0);
    sync_match_flag <= 1'b1;
    timeout_flag <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(34'(radio_mode), 34'(pla_pkg::PLA_MODE_DOZE));
    @(posedge aclk);
    sync_match_flag <= 1'b0;
    timeout_flag <= 1'b0;
    // entry code off: forced return, then no switching
    wr(`PLA_IDX_AUTO, 8'h1A);
    sync_match_flag <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(34'(radio_mode), 34'(pla_pkg::PLA_MODE_TX));
    end_of_test();
  end
endmodule // packet_length_address_automode_tb_top
